//--- hw/cid_pkg.sv
// Shared constants and types for the instruction decode and timing core
package cid_pkg;
   // ==========================================================
   // Widths
   localparam int INSTR_W   = 14;
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 7;
   localparam int PHASES    = 4;
   localparam int N_PTR     = 2;
   // ==========================================================
   // Field positions
   localparam int FLD_PFX_HI  = 13;
   localparam int FLD_PFX_LO  = 12;
   localparam int FLD_OP_HI   = 11;
   localparam int FLD_OP_LO   = 8;
   localparam int FLD_DEST    = 7;
   localparam int FLD_F_HI    = 6;
   localparam int FLD_BIT_HI  = 9;
   localparam int FLD_BIT_LO  = 7;
   localparam int FLD_BOP_HI  = 11;
   localparam int FLD_BOP_LO  = 10;
   localparam int FLD_PTR_N   = 2;
   localparam int FLD_PTR_DIR = 3;
   // ==========================================================
   // Prefix codes, zero-operand codes and opcode nibbles
   localparam logic [1:0] PFX_BYTE = 2'h0;
   localparam logic [1:0] PFX_BIT  = 2'h1;
   localparam logic [1:0] PFX_JUMP = 2'h2;
   localparam logic [1:0] PFX_LIT  = 2'h3;
   localparam logic [7:0] MISC_RETURN  = 8'h08;
   localparam logic [7:0] MISC_RET_INT = 8'h09;
   localparam logic [7:0] MISC_CALL_W  = 8'h0a;
   localparam logic [7:0] MISC_BR_W    = 8'h0b;
   localparam logic [3:0] MISC_PTR_HI  = 4'h1;
   localparam logic [3:0] LIT_BR_HI    = 4'h1;
   localparam logic [3:0] LIT_RET_K    = 4'h4;
   // ==========================================================
   // Bit operation codes
   localparam logic [1:0] BOP_CLR  = 2'h0;
   localparam logic [1:0] BOP_SET  = 2'h1;
   localparam logic [1:0] BOP_SKC  = 2'h2;
   localparam logic [1:0] BOP_SKS  = 2'h3;
   // ==========================================================
   // Reset values
   localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
   localparam logic [DATA_W-1:0]  W_RST     = 8'h00;
   localparam logic [PHASES-1:0]  PHASE_RST = 4'h1;

   typedef enum logic [1:0] {
      CID_FMT_BYTE = 2'b00,
      CID_FMT_BIT  = 2'b01,
      CID_FMT_LIT  = 2'b10
   } cid_fmt_t;

   typedef enum logic [1:0] {
      CID_ST_EXEC = 2'b00,
      CID_ST_WAIT = 2'b01,
      CID_ST_NOP  = 2'b10
   } cid_state_t;
endpackage : cid_pkg

//--- hw/cid_phase_seq.sv
// Four-phase instruction cycle sequencer
module cid_phase_seq (
   input  wire logic                      i_clk,
   input  wire logic                      i_reset_n,
   output logic [cid_pkg::PHASES-1:0]     o_phase_en
);
   // ==========================================================
   // One-hot ring, first phase out of reset
   logic [cid_pkg::PHASES-1:0] ring_reg;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ring_reg <= cid_pkg::PHASE_RST; // see [RULE_18]
      end else begin
         ring_reg <= {ring_reg[cid_pkg::PHASES-2:0],
                      ring_reg[cid_pkg::PHASES-1]}; // see [RULE_08]
      end
   end

   assign o_phase_en = ring_reg;
endmodule : cid_phase_seq

//--- hw/cid_core.sv
// Instruction decode, execution and cycle timing core
// Function
// [RULE_01] One 14-bit word holds opcode and operands
// [RULE_02] Classify into byte, bit, literal/control
// [RULE_03] Plain instructions finish in one cycle
// [RULE_04] Calls take two instruction cycles
// [RULE_05] Returns take two instruction cycles
// [RULE_06] Jumps, branches and skips take two cycles
// [RULE_07] Indirect access to program memory adds cycle
// [RULE_08] Instruction cycle is four clock phases
// [RULE_09] File operands are read, modified, stored
// [RULE_10] Read happens even for write-only instructions
// [RULE_11] File address field spans 0x00 to 0x7F
// [RULE_12] Bit field picks one of eight bits
// [RULE_13] Destination bit: 0 to W, 1 to file
// [RULE_14] Don't-care bits never change execution
// [RULE_15] Pointer field selects pair 0 or 1
// [RULE_16] Two-bit mode selects pointer pre/post step
// [RULE_17] Second cycle of two-cycle op is idle
// [RULE_18] Reset starts at phase one, nothing pending
module cid_core (
   input  wire logic                          i_clk,
   input  wire logic                          i_reset_n,
   input  wire logic [cid_pkg::INSTR_W-1:0]   i_instr,
   input  wire logic [cid_pkg::DATA_W-1:0]    i_file_rdata,
   input  wire logic [cid_pkg::N_PTR-1:0]     i_ptr_in_prog,
   output logic                               o_instr_take,
   output logic                               o_file_rd,
   output logic                               o_file_wr,
   output logic [cid_pkg::ADDR_W-1:0]         o_file_addr,
   output logic [cid_pkg::DATA_W-1:0]         o_file_wdata,
   output logic [1:0]                         o_fmt,
   output logic                               o_flow_change,
   output logic                               o_skip,
   output logic                               o_nop_cycle,
   output logic                               o_ptr_update,
   output logic                               o_ptr_sel,
   output logic [1:0]                         o_ptr_mode,
   output logic [cid_pkg::DATA_W-1:0]         o_w,
   output logic                               o_carry,
   output logic                               o_zero
);
   // ==========================================================
   // Decode functions
   function automatic cid_pkg::cid_fmt_t fmt_of(input logic [13:0] ins);
      logic [3:0] op;
      op = ins[cid_pkg::FLD_OP_HI:cid_pkg::FLD_OP_LO];
      case (ins[cid_pkg::FLD_PFX_HI:cid_pkg::FLD_PFX_LO])
         cid_pkg::PFX_BYTE: fmt_of = (ins[11:7] == 5'h00) ? cid_pkg::CID_FMT_LIT
                                                         : cid_pkg::CID_FMT_BYTE;
         cid_pkg::PFX_BIT:  fmt_of = cid_pkg::CID_FMT_BIT;
         cid_pkg::PFX_LIT:  fmt_of = (op == 4'h5 || op == 4'h6 || op == 4'h7 ||
                                      op == 4'hb || op == 4'hd)
                                     ? cid_pkg::CID_FMT_BYTE : cid_pkg::CID_FMT_LIT;
         default:           fmt_of = cid_pkg::CID_FMT_LIT;
      endcase
   endfunction : fmt_of

   function automatic logic is_misc(input logic [13:0] ins);
      is_misc = (ins[13:7] == 7'h00);
   endfunction : is_misc

   function automatic logic is_flow(input logic [13:0] ins);
      logic [1:0] pfx;
      pfx = ins[cid_pkg::FLD_PFX_HI:cid_pkg::FLD_PFX_LO];
      is_flow = (pfx == cid_pkg::PFX_JUMP) ||
                (is_misc(ins) && (ins[7:0] == cid_pkg::MISC_RETURN ||
                                  ins[7:0] == cid_pkg::MISC_RET_INT ||
                                  ins[7:0] == cid_pkg::MISC_CALL_W ||
                                  ins[7:0] == cid_pkg::MISC_BR_W)) ||
                (pfx == cid_pkg::PFX_LIT && (ins[11:9] == cid_pkg::LIT_BR_HI[2:0] ||
                                             ins[11:8] == cid_pkg::LIT_RET_K));
   endfunction : is_flow

   function automatic logic is_call(input logic [13:0] ins);
      is_call = (ins[13:11] == 3'h4) ||
                (is_misc(ins) && ins[7:0] == cid_pkg::MISC_CALL_W);
   endfunction : is_call

   // ==========================================================
   // Phase sequencer
   logic [cid_pkg::PHASES-1:0] phase_en;
   cid_phase_seq u_seq (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .o_phase_en (phase_en)
   );
   logic q1_en, q2_en, q3_en, q4_en;
   assign q1_en = phase_en[0];
   assign q2_en = phase_en[1];
   assign q3_en = phase_en[2];
   assign q4_en = phase_en[3];

   // ==========================================================
   // Instruction register and decoded fields
   cid_pkg::cid_state_t state_reg;
   logic [13:0]         instr_reg;
   logic [7:0]          rdata_reg;
   logic [7:0]          result_reg;
   logic [7:0]          w_reg;
   logic                c_reg;
   logic                z_reg;
   logic                c_next_reg;
   logic                skip_reg;
   logic                wr_w_reg;
   logic                wr_f_reg;

   cid_pkg::cid_fmt_t   fmt;
   logic [3:0]          opc;
   logic [1:0]          bop;
   logic [2:0]          bnum;
   logic                dest_f;
   logic                clr_w;
   logic                ptr_op;
   logic                ptr_n;
   logic                names_file;
   logic                indirect;
   logic                ind_stall;
   logic                commit;
   logic                two_cycle;
   logic [7:0]          bmask;

   assign fmt    = fmt_of(instr_reg); // see [RULE_02]
   assign opc    = instr_reg[cid_pkg::FLD_OP_HI:cid_pkg::FLD_OP_LO]; // see [RULE_01]
   assign bop    = instr_reg[cid_pkg::FLD_BOP_HI:cid_pkg::FLD_BOP_LO];
   assign bnum   = instr_reg[cid_pkg::FLD_BIT_HI:cid_pkg::FLD_BIT_LO];
   assign bmask  = 8'h01 << bnum; // see [RULE_12]
   assign dest_f = instr_reg[cid_pkg::FLD_DEST]; // see [RULE_13]
   // Clear-W ignores its seven low bits and names no file register
   assign clr_w  = (instr_reg[13:7] == 7'h02); // see [RULE_14]
   assign ptr_op = is_misc(instr_reg) && instr_reg[7:4] == cid_pkg::MISC_PTR_HI;
   assign ptr_n  = ptr_op ? instr_reg[cid_pkg::FLD_PTR_N]
                          : instr_reg[0]; // see [RULE_15]
   assign names_file = (fmt == cid_pkg::CID_FMT_BYTE && !clr_w) ||
                       (fmt == cid_pkg::CID_FMT_BIT) || ptr_op;
   assign indirect  = ptr_op || (names_file && instr_reg[6:1] == 6'h00);
   assign ind_stall = indirect && i_ptr_in_prog[ptr_n]; // see [RULE_07]
   assign commit    = q4_en && ((state_reg == cid_pkg::CID_ST_EXEC && !ind_stall) ||
                                state_reg == cid_pkg::CID_ST_WAIT);
   assign two_cycle = is_flow(instr_reg) || skip_reg; // see [RULE_04] [RULE_05] [RULE_06]

   // ==========================================================
   // Execution state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= cid_pkg::CID_ST_EXEC; // see [RULE_18]
      end else if (q4_en) begin
         case (state_reg)
            cid_pkg::CID_ST_EXEC: begin
               if (ind_stall)
                  state_reg <= cid_pkg::CID_ST_WAIT; // see [RULE_07]
               else if (two_cycle)
                  state_reg <= cid_pkg::CID_ST_NOP; // see [RULE_17]
            end
            cid_pkg::CID_ST_WAIT: begin
               state_reg <= two_cycle ? cid_pkg::CID_ST_NOP : cid_pkg::CID_ST_EXEC;
            end
            default: state_reg <= cid_pkg::CID_ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         instr_reg <= cid_pkg::INSTR_RST; // see [RULE_18]
      end else if (o_instr_take) begin
         instr_reg <= i_instr; // see [RULE_01]
      end
   end

   // Read phase, also for instructions that only write
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_reg <= 8'h00;
      end else if (o_file_rd) begin
         rdata_reg <= i_file_rdata; // see [RULE_09] [RULE_10]
      end
   end

   // ==========================================================
   // Modify phase
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      logic [8:0] sum;
      logic [7:0] f;
      logic [7:0] k;
      sum = 9'h000;
      f   = rdata_reg;
      k   = instr_reg[7:0];
      if (!i_reset_n) begin
         result_reg <= 8'h00;
         c_next_reg <= 1'b0;
         skip_reg   <= 1'b0;
         wr_w_reg   <= 1'b0;
         wr_f_reg   <= 1'b0;
      end else if (q3_en && state_reg != cid_pkg::CID_ST_NOP) begin
         result_reg <= 8'h00;
         c_next_reg <= c_reg;
         skip_reg   <= 1'b0;
         wr_w_reg   <= 1'b0;
         wr_f_reg   <= 1'b0;
         if (fmt == cid_pkg::CID_FMT_BYTE) begin
            wr_w_reg <= !dest_f; // see [RULE_13]
            wr_f_reg <= dest_f;
            case ({instr_reg[13], opc})
               5'h00: begin result_reg <= w_reg; wr_w_reg <= 1'b0; wr_f_reg <= 1'b1; end
               5'h01: result_reg <= 8'h00;
               5'h02, 5'h1b: begin
                  sum = {1'b0, f} + {1'b0, ~w_reg} +
                        {8'h00, (instr_reg[13] ? c_reg : 1'b1)};
                  result_reg <= sum[7:0];
                  c_next_reg <= sum[8];
               end
               5'h03, 5'h0b: begin
                  result_reg <= f - 8'h01;
                  skip_reg   <= (opc == 4'hb) && (f == 8'h01); // see [RULE_06]
               end
               5'h04: result_reg <= f | w_reg;
               5'h05: result_reg <= f & w_reg;
               5'h06: result_reg <= f ^ w_reg;
               5'h07, 5'h1d: begin
                  sum = {1'b0, f} + {1'b0, w_reg} +
                        {8'h00, (instr_reg[13] & c_reg)};
                  result_reg <= sum[7:0];
                  c_next_reg <= sum[8];
               end
               5'h08: result_reg <= f;
               5'h09: result_reg <= ~f;
               5'h0a, 5'h0f: begin
                  result_reg <= f + 8'h01;
                  skip_reg   <= (opc == 4'hf) && (f == 8'hff); // see [RULE_06]
               end
               5'h0c: begin result_reg <= {c_reg, f[7:1]}; c_next_reg <= f[0]; end
               5'h0d: begin result_reg <= {f[6:0], c_reg}; c_next_reg <= f[7]; end
               5'h0e: result_reg <= {f[3:0], f[7:4]};
               5'h15: begin result_reg <= {f[6:0], 1'b0}; c_next_reg <= f[7]; end
               5'h16: begin result_reg <= {1'b0, f[7:1]}; c_next_reg <= f[0]; end
               5'h17: begin result_reg <= {f[7], f[7:1]}; c_next_reg <= f[0]; end
               default: result_reg <= f;
            endcase
         end else if (fmt == cid_pkg::CID_FMT_BIT) begin
            result_reg <= (bop == cid_pkg::BOP_SET) ? (f | bmask)
                                                    : (f & ~bmask); // see [RULE_12]
            wr_f_reg   <= (bop == cid_pkg::BOP_CLR) || (bop == cid_pkg::BOP_SET);
            if (bop == cid_pkg::BOP_SKC)
               skip_reg <= ((f & bmask) == 8'h00); // see [RULE_06]
            else if (bop == cid_pkg::BOP_SKS)
               skip_reg <= ((f & bmask) != 8'h00); // see [RULE_06]
         end else if (ptr_op) begin
            result_reg <= instr_reg[cid_pkg::FLD_PTR_DIR] ? w_reg : f;
            wr_f_reg   <= instr_reg[cid_pkg::FLD_PTR_DIR];
            wr_w_reg   <= !instr_reg[cid_pkg::FLD_PTR_DIR];
         end else if (instr_reg[13:12] == cid_pkg::PFX_LIT) begin
            wr_w_reg <= 1'b1;
            case (opc)
               4'h0, cid_pkg::LIT_RET_K: result_reg <= k;
               4'h8: result_reg <= k | w_reg;
               4'h9: result_reg <= k & w_reg;
               4'ha: result_reg <= k ^ w_reg;
               4'hc: begin
                  sum = {1'b0, k} + {1'b0, ~w_reg} + 9'h001;
                  result_reg <= sum[7:0];
                  c_next_reg <= sum[8];
               end
               4'he: begin
                  sum = {1'b0, k} + {1'b0, w_reg};
                  result_reg <= sum[7:0];
                  c_next_reg <= sum[8];
               end
               default: begin result_reg <= w_reg; wr_w_reg <= 1'b0; end
            endcase
         end
      end
   end

   // ==========================================================
   // Store phase: working register and flags
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         w_reg <= cid_pkg::W_RST;
         c_reg <= 1'b0;
         z_reg <= 1'b0;
      end else if (commit) begin
         if (wr_w_reg)
            w_reg <= result_reg; // see [RULE_09] [RULE_13]
         c_reg <= c_next_reg;
         if (wr_w_reg || wr_f_reg)
            z_reg <= (result_reg == 8'h00);
      end
   end

   // ==========================================================
   // Outputs
   assign o_instr_take  = q1_en && state_reg == cid_pkg::CID_ST_EXEC; // see [RULE_03]
   assign o_file_rd     = q2_en && names_file &&
                          state_reg != cid_pkg::CID_ST_NOP; // see [RULE_10]
   assign o_file_addr   = ptr_op ? {6'h00, ptr_n}
                                 : instr_reg[cid_pkg::FLD_F_HI:0]; // see [RULE_11]
   assign o_file_wr     = commit && wr_f_reg; // see [RULE_09]
   assign o_file_wdata  = result_reg;
   assign o_fmt         = fmt;
   assign o_flow_change = commit && is_flow(instr_reg);
   assign o_skip        = commit && skip_reg;
   assign o_nop_cycle   = (state_reg == cid_pkg::CID_ST_NOP); // see [RULE_17]
   assign o_ptr_update  = commit && ptr_op;
   assign o_ptr_sel     = ptr_n;
   assign o_ptr_mode    = instr_reg[1:0]; // see [RULE_16]
   assign o_w           = w_reg;
   assign o_carry       = c_reg;
   assign o_zero        = z_reg;

   // ==========================================================
   // Checks
   logic rd_seen_reg;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         rd_seen_reg <= 1'b0;
      else if (o_file_rd)
         rd_seen_reg <= 1'b1;
      else if (o_file_wr)
         rd_seen_reg <= 1'b0;
   end

   sequence s_phases;
      q1_en ##1 q2_en ##1 q3_en ##1 q4_en;
   endsequence
   sequence s_idle_cycle;
      o_nop_cycle [*4] ##1 o_instr_take;
   endsequence

   property p_phase_ring;
      @(posedge i_clk) disable iff (!i_reset_n) q1_en |-> s_phases;
   endproperty
   a_phase_ring: assert property (p_phase_ring) // see [RULE_08]
      else $error("phase order broken");

   property p_one_cycle;
      @(posedge i_clk) disable iff (!i_reset_n)
         (commit && !two_cycle) |=> o_instr_take;
   endproperty
   a_one_cycle: assert property (p_one_cycle) // see [RULE_03]
      else $error("single cycle op not followed by fetch");

   property p_call_two;
      @(posedge i_clk) disable iff (!i_reset_n)
         (commit && is_call(instr_reg)) |=> s_idle_cycle;
   endproperty
   a_call_two: assert property (p_call_two) // see [RULE_04]
      else $error("call not two cycles");

   property p_flow_two;
      @(posedge i_clk) disable iff (!i_reset_n)
         (o_flow_change || o_skip) |=> s_idle_cycle;
   endproperty
   a_flow_two: assert property (p_flow_two) // see [RULE_06]
      else $error("flow change not followed by idle cycle");

   property p_ret_idle;
      @(posedge i_clk) disable iff (!i_reset_n)
         (commit && is_flow(instr_reg) && !is_call(instr_reg)) |=>
            (!o_file_wr && !o_file_rd) [*4];
   endproperty
   a_ret_idle: assert property (p_ret_idle) // see [RULE_05]
      else $error("second cycle of return not idle");

   property p_ind_extra;
      @(posedge i_clk) disable iff (!i_reset_n)
         (q4_en && state_reg == cid_pkg::CID_ST_EXEC && ind_stall) |=>
            (state_reg == cid_pkg::CID_ST_WAIT && !o_instr_take) [*4] ##1
            (o_instr_take || o_nop_cycle);
   endproperty
   a_ind_extra: assert property (p_ind_extra) // see [RULE_07]
      else $error("indirect stall missing");

   property p_read_first;
      @(posedge i_clk) disable iff (!i_reset_n) o_file_wr |-> rd_seen_reg;
   endproperty
   a_read_first: assert property (p_read_first) // see [RULE_10]
      else $error("file write without prior read");

   property p_addr;
      @(posedge i_clk) disable iff (!i_reset_n)
         (o_file_rd && !ptr_op) |-> o_file_addr == instr_reg[6:0];
   endproperty
   a_addr: assert property (p_addr) // see [RULE_11]
      else $error("file address not from operand");

   property p_bit_only;
      @(posedge i_clk) disable iff (!i_reset_n)
         (o_file_wr && fmt == cid_pkg::CID_FMT_BIT) |->
            ((o_file_wdata ^ rdata_reg) & ~bmask) == 8'h00;
   endproperty
   a_bit_only: assert property (p_bit_only) // see [RULE_12]
      else $error("bit op touched other bits");

   property p_dest_w;
      @(posedge i_clk) disable iff (!i_reset_n)
         (commit && fmt == cid_pkg::CID_FMT_BYTE && opc != 4'h0 && !dest_f) |->
            !o_file_wr ##1 o_w == $past(result_reg);
   endproperty
   a_dest_w: assert property (p_dest_w) // see [RULE_13]
      else $error("d=0 result not in W");
endmodule : cid_core

//--- tb/cid_file_model.sv
// Data file register model facing the core
module cid_file_model (
   input  wire logic       i_clk,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [6:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [128];
   // ==========================================================
   // Contents start as their own address
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i);
   end
   // Inverse value while not read, so stale data never matches
   assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
   always @(posedge i_clk) begin
      if (i_wr) mem[i_addr] <= i_wdata;
   end
endmodule : cid_file_model

//--- tb/test_cid_core.sv
// Self-checking bench for the instruction decode and timing core
module test_cid_core;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_clk = 1'b0, i_reset_n = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0]  i_file_rdata, o_file_wdata, o_w;
   logic [1:0]  i_ptr_in_prog = 2'h0, o_fmt, o_ptr_mode;
   logic [6:0]  o_file_addr;
   logic        o_instr_take, o_file_rd, o_file_wr, o_flow_change, o_skip;
   logic        o_nop_cycle, o_ptr_update, o_ptr_sel, o_carry, o_zero, saw_rd;
   logic [2:0]  pu;
   int          error_cnt = 0, check_count = 0, cyc = 0, w, a, k;
   int          fm [128];
   logic [31:0] seed = 32'd54;
   logic [13:0] flow [8] = '{14'h2805, 14'h2003, 14'h0008, 14'h0009,
                             14'h000a, 14'h000b, 14'h3412, 14'h3205};
   cid_core uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr(i_instr),
      .i_file_rdata(i_file_rdata), .i_ptr_in_prog(i_ptr_in_prog),
      .o_instr_take(o_instr_take), .o_file_rd(o_file_rd), .o_file_wr(o_file_wr),
      .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_fmt(o_fmt),
      .o_flow_change(o_flow_change), .o_skip(o_skip), .o_nop_cycle(o_nop_cycle),
      .o_ptr_update(o_ptr_update), .o_ptr_sel(o_ptr_sel), .o_ptr_mode(o_ptr_mode),
      .o_w(o_w), .o_carry(o_carry), .o_zero(o_zero));
   cid_file_model u_mem (.i_clk(i_clk), .i_rd(o_file_rd), .i_wr(o_file_wr),
      .i_addr(o_file_addr), .i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
   always #2 i_clk = ~i_clk;
   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // Run one instruction, check its length in clocks
   task automatic exe(input logic [13:0] ins, input int ncyc);
      int n;
      i_instr = ins;
      n = 0;
      while (o_instr_take !== 1'b1 && n < 16) begin
         @(posedge i_clk); #1; n++;
      end
      saw_rd = 1'b0;
      n = 0;
      do begin
         @(posedge i_clk); #1; n++;
         if (o_file_rd === 1'b1) saw_rd = 1'b1;
         if (o_ptr_update === 1'b1) pu = {o_ptr_sel, o_ptr_mode};
      end while (o_instr_take !== 1'b1 && n < 16);
      chk(8'(n), 8'(ncyc));
   endtask : exe
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 128; i++) fm[i] = i;
      repeat (3) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      chk(o_w, 8'h00);
      chk({7'h00, o_instr_take}, 8'h01);
      exe(14'h3025, 4); w = 8'h25;
      chk(o_w, 8'(w));
      chk({6'h00, o_fmt}, 8'h02);
      exe(14'h0790, 4); fm[16] = (fm[16] + w) & 255;
      chk(u_mem.mem[16], 8'(fm[16]));
      chk({6'h00, o_fmt}, 8'h00);
      chk({7'h00, o_carry}, 8'h00);
      exe(14'h0711, 4); w = (fm[17] + w) & 255;
      chk(o_w, 8'(w));
      chk(u_mem.mem[17], 8'(fm[17]));
      $display("test byte ops done");
      foreach (flow[i]) exe(flow[i], 8);
      chk(o_w, 8'h12);
      w = 8'h12;
      exe(14'h1820, 8);
      exe(14'h1aa0, 4);
      chk({6'h00, o_fmt}, 8'h01);
      exe(14'h1ea0, 8);
      exe(14'h0b81, 8); fm[1] = 0;
      exe(14'h0f82, 4); fm[2] = 3;
      chk(u_mem.mem[2], 8'(fm[2]));
      $display("test flow timing done");
      i_ptr_in_prog = 2'h1;
      exe(14'h0700, 8); w = (fm[0] + w) & 255;
      exe(14'h0701, 4); w = (fm[1] + w) & 255;
      i_ptr_in_prog = 2'h2;
      exe(14'h0701, 8); w = (fm[1] + w) & 255;
      i_ptr_in_prog = 2'h0;
      chk(o_w, 8'(w));
      for (int i = 0; i < 4; i++) exe(14'(i * 32), 4);
      chk(o_w, 8'(w));
      exe(14'h0103, 4); w = 0;
      chk(o_w, 8'(w));
      chk({7'h00, o_zero}, 8'h01);
      for (int i = 0; i < 8; i++) begin
         exe(14'h0010 | 14'(i), 4);
         chk({5'h00, pu}, 8'(i[2:0]));
      end
      $display("test indirect done");
      for (int i = 0; i < 8; i++) begin
         k = int'(rnd() & 32'hff);
         a = 2 + int'(rnd() % 32'd126);
         exe(14'h3000 | 14'(k), 4); w = k;
         exe(14'h0080 | 14'(a), 4); fm[a] = w;
         chk({7'h00, saw_rd}, 8'h01);
         chk(u_mem.mem[a], 8'(fm[a]));
      end
      $display("test random moves done");
      report_and_stop();
   end
endmodule : test_cid_core
